/* File: logic/tpsc_cfg.svh */
// Purpose: Constants of the tuner synthesizer serial control block
// Assumes: Included by the package, tpsc_sync and tpsc_serial_ctrl
// Notes:   Definitions only
`ifndef TPSC_CFG_SVH
`define TPSC_CFG_SVH

// ----------------------------------------
// Bus framing
// ----------------------------------------
`define TPSC_ADDR_FIXED 5'h18
`define TPSC_BIT_LAST 4'h8
`define TPSC_BIT_FIRST 4'h1
`define TPSC_BIT_NONE 4'h0
`define TPSC_MSB 7
`define TPSC_SYNC_W 11

// ----------------------------------------
// Synchroniser bit lanes
// ----------------------------------------
`define TPSC_LN_SCL 0
`define TPSC_LN_SDA 1
`define TPSC_LN_LOCK 2
`define TPSC_LN_AGC 3
`define TPSC_LN_STRAP_LO 4
`define TPSC_LN_STRAP_HI 6
`define TPSC_LN_CONV_LO 7
`define TPSC_LN_CONV_HI 10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TPSC_CB_CP 6
`define TPSC_CB_T_HI 5
`define TPSC_CB_T_LO 3
`define TPSC_CB_RS_HI 2
`define TPSC_CB_RS_LO 1
`define TPSC_CB_OS 0
`define TPSC_AB_ATC 7
`define TPSC_AB_AL_HI 6
`define TPSC_AB_AL_LO 4
`define TPSC_BB_P6 6
`define TPSC_BB_P4 4
`define TPSC_BB_P3 3
`define TPSC_BB_P0 0
`define TPSC_BB_P1 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TPSC_CB_RESET 8'hc9
`define TPSC_BB_RESET 8'h00
`define TPSC_AB_RESET 8'h20
`define TPSC_DIV_RESET 15'h0000
`define TPSC_STATUS_ONES 2'h3

// ----------------------------------------
// Codes and decoded values
// ----------------------------------------
`define TPSC_TEST_PUMP_OFF 3'h2
`define TPSC_TEST_AUX 3'h3
`define TPSC_TEST_HALF_REF 3'h4
`define TPSC_TEST_HALF_DIV 3'h5
`define TPSC_TEST_SINK 3'h6
`define TPSC_TEST_SOURCE 3'h7
`define TPSC_RS_80 2'h0
`define TPSC_RS_128 2'h1
`define TPSC_RS_BAD 2'h2
`define TPSC_RATIO_80 8'h50
`define TPSC_RATIO_128 8'h80
`define TPSC_RATIO_64 8'h40
`define TPSC_AL_112 3'h2
`define TPSC_AL_109 3'h3
`define TPSC_AL_106 3'h4
`define TPSC_AL_103 3'h5
`define TPSC_AL_EXT 3'h6
`define TPSC_AL_FIXED 3'h7
`define TPSC_DB_115 7'h73
`define TPSC_DB_112 7'h70
`define TPSC_DB_109 7'h6d
`define TPSC_DB_106 7'h6a
`define TPSC_DB_103 7'h67
`define TPSC_DB_NONE 7'h00

`endif

/* File: logic/tpsc_pkg.sv */
// Purpose: Types of the tuner synthesizer serial control block
// Assumes: tpsc_cfg.svh holds the numbers
// Notes:   States, pointers and carriers
`default_nettype none
`include "tpsc_cfg.svh"
package tpsc_pkg;
	typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_ADDR_ACK, PH_WRITE, PH_WRITE_ACK,
		PH_READ, PH_READ_ACK} tpsc_phase_t;
	typedef enum logic [2:0] {PT_FIRST, PT_DIV1, PT_DIV2, PT_CTRL, PT_PORT,
		PT_DONE} tpsc_ptr_t;
	typedef enum logic [1:0] {PUMP_NORMAL, PUMP_OFF, PUMP_SINK, PUMP_SOURCE} tpsc_pump_t;

	typedef struct packed {
		logic [14:0] dividerCount;
		logic pumpCurrentSelect;
		tpsc_pump_t pumpMode;
		logic halfRefOnPort6;
		logic halfDivOnPort6;
		logic converterBlocked;
		logic [7:0] refRatio;
		logic refRatioForbidden;
		logic [6:0] takeoverDbuv;
		logic agcDetectorOn;
		logic agcOutHiZ;
		logic agcOutForced;
		logic gainTimeConstant;
		logic tuningOutputOff;
		logic [7:0] portBits;
		logic highBandSelect;
	} tpsc_cfg_t;

	typedef struct packed {
		logic [`TPSC_SYNC_W-1:0] meta;
		logic [`TPSC_SYNC_W-1:0] stable;
	} tpsc_sync_t;

	typedef struct packed {
		logic sclPrev;
		logic sdaPrev;
		tpsc_phase_t phase;
		tpsc_ptr_t ptr;
		logic fromCtl;
		logic isRead;
		logic ackSeen;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic sdaOe;
		logic sdaOut;
		logic [6:0] db1;
		logic [7:0] cb;
		logic [7:0] bb;
		logic [7:0] ab;
		logic por;
		logic [1:0] strapCode;
		tpsc_cfg_t cfg;
	} tpsc_state_t;
endpackage : tpsc_pkg
`default_nettype wire

/* File: logic/tpsc_sync.sv */
// Purpose: Two-stage synchroniser for all pin-level inputs
// Assumes: Inputs may change at any time
// Notes:   Only the second stage leaves the module
`default_nettype none
`include "tpsc_cfg.svh"
module tpsc_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [`TPSC_SYNC_W-1:0] async,
	output logic [`TPSC_SYNC_W-1:0] synced
);
	import tpsc_pkg::*;
	tpsc_sync_t q;
	tpsc_sync_t d;

	always_comb begin
		d.meta = async;
		d.stable = q.meta;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign synced = q.stable;
endmodule : tpsc_sync
`default_nettype wire

/* File: logic/tpsc_therm.sv */
// Purpose: Thermometer comparator word to band code
// Assumes: Comparator outputs already synchronised
// Notes:   Counts ones, so one bubble costs one band at most
`default_nettype none
module tpsc_therm #(
	parameter int IW = 4,
	parameter int OW = 3
) (
	input wire logic [IW-1:0] therm,
	output logic [OW-1:0] code
);
	always_comb begin
		code = '0;
		for (int i = 0; i < IW; i++) begin
			code = code + OW'(therm[i]);
		end
	end
endmodule : tpsc_therm
`default_nettype wire

/* File: logic/tpsc_serial_ctrl.sv */
// Purpose: Two-wire slave, control registers and status byte of a tuner synthesizer
// Assumes: scl and the sda input come from pins; open-drain sda outside
// Notes:   Registers decode into tunerCfg, every output registered
`default_nettype none
`include "tpsc_cfg.svh"
module tpsc_serial_ctrl (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic scl,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic [2:0] addrStrapPinLevel,
	input wire logic [3:0] convCompare,
	input wire logic loopLocked,
	input wire logic agcTakeoverReached,
	output tpsc_pkg::tpsc_cfg_t tunerCfg,
	output logic porFlag
);
	import tpsc_pkg::*;

	// ----------------------------------------
	// Input synchronisation
	// ----------------------------------------
	logic [`TPSC_SYNC_W-1:0] syncIn;
	logic [`TPSC_SYNC_W-1:0] syncOut;
	logic [1:0] strapNow;
	logic [2:0] convCode;
	logic sclS;
	logic sdaS;

	assign syncIn = {convCompare, addrStrapPinLevel, agcTakeoverReached, loopLocked,
		sdaIn, scl};

	tpsc_sync u_sync (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.async(syncIn),
		.synced(syncOut)
	);

	// Strap comparators sit between the four voltage bands
	tpsc_therm #(.IW(3), .OW(2)) u_strap (
		.therm(syncOut[`TPSC_LN_STRAP_HI:`TPSC_LN_STRAP_LO]),
		.code(strapNow)
	);

	tpsc_therm #(.IW(4), .OW(3)) u_conv (
		.therm(syncOut[`TPSC_LN_CONV_HI:`TPSC_LN_CONV_LO]),
		.code(convCode)
	);

	assign sclS = syncOut[`TPSC_LN_SCL];
	assign sdaS = syncOut[`TPSC_LN_SDA];

	// ----------------------------------------
	// Bus events
	// ----------------------------------------
	tpsc_state_t q;
	tpsc_state_t d;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;
	logic byteDone;
	logic addrMatch;
	logic [7:0] statusByte;
	tpsc_ptr_t ptrSel;

	assign sclRise = sclS & ~q.sclPrev;
	assign sclFall = ~sclS & q.sclPrev;
	assign startSeen = sclS & q.sclPrev & q.sdaPrev & ~sdaS;
	assign stopSeen = sclS & q.sclPrev & ~q.sdaPrev & sdaS;
	assign byteDone = sclFall & (q.bitCnt == `TPSC_BIT_LAST);
	assign addrMatch = (q.shift[7:1] == {`TPSC_ADDR_FIXED, q.strapCode});
	assign statusByte = {q.por, syncOut[`TPSC_LN_LOCK], `TPSC_STATUS_ONES,
		syncOut[`TPSC_LN_AGC], convCode};
	assign ptrSel = (q.ptr != PT_FIRST) ? q.ptr :
		(q.shift[`TPSC_MSB] ? PT_CTRL : PT_DIV1);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		d = q;
		d.sclPrev = sclS;
		d.sdaPrev = sdaS;
		d.sdaOut = 1'b0;
		if (startSeen) begin
			d.phase = PH_ADDR;
			d.bitCnt = `TPSC_BIT_NONE;
			d.sdaOe = 1'b0;
		end else if (stopSeen) begin
			d.phase = PH_IDLE;
			d.sdaOe = 1'b0;
		end else begin
			case (q.phase)
				PH_IDLE: begin
					// Strap followed only between transfers
					d.strapCode = strapNow;
				end
				PH_ADDR, PH_WRITE: begin
					if (sclRise) begin
						d.shift = {q.shift[6:0], sdaS};
						d.bitCnt = q.bitCnt + `TPSC_BIT_FIRST;
					end else if (byteDone) begin
						if (q.phase == PH_ADDR) begin
							if (addrMatch) begin
								d.sdaOe = 1'b1;
								d.isRead = q.shift[0];
								d.ptr = PT_FIRST;
								d.phase = PH_ADDR_ACK;
							end else begin
								d.phase = PH_IDLE;
							end
						end else begin
							d.sdaOe = 1'b1;
							d.phase = PH_WRITE_ACK;
							if (q.ptr == PT_FIRST) begin
								d.fromCtl = q.shift[`TPSC_MSB];
							end
							// Load on the fall of the eighth clock
							case (ptrSel)
								PT_DIV1: begin
									d.db1 = q.shift[6:0];
									d.ptr = PT_DIV2;
								end
								PT_DIV2: begin
									d.cfg.dividerCount = {q.db1, q.shift};
									d.ptr = d.fromCtl ? PT_DONE : PT_CTRL;
								end
								PT_CTRL: begin
									d.cb = q.shift;
									d.ptr = PT_PORT;
								end
								PT_PORT: begin
									if (q.cb[`TPSC_CB_T_HI:`TPSC_CB_T_LO] == `TPSC_TEST_AUX) begin
										d.ab = q.shift;
									end else begin
										d.bb = q.shift;
									end
									d.ptr = d.fromCtl ? PT_DIV1 : PT_DONE;
								end
								default: begin
									// Surplus bytes are acknowledged and dropped
									d.ptr = PT_DONE;
								end
							endcase
						end
					end
				end
				PH_ADDR_ACK: begin
					if (sclFall) begin
						if (q.isRead) begin
							d.shift = statusByte;
							d.sdaOe = ~statusByte[`TPSC_MSB];
							d.bitCnt = `TPSC_BIT_FIRST;
							d.phase = PH_READ;
						end else begin
							d.sdaOe = 1'b0;
							d.bitCnt = `TPSC_BIT_NONE;
							d.phase = PH_WRITE;
						end
					end
				end
				PH_WRITE_ACK: begin
					if (sclFall) begin
						d.sdaOe = 1'b0;
						d.bitCnt = `TPSC_BIT_NONE;
						d.phase = PH_WRITE;
					end
				end
				PH_READ: begin
					if (byteDone) begin
						d.sdaOe = 1'b0;
						d.ackSeen = 1'b0;
						d.phase = PH_READ_ACK;
					end else if (sclFall) begin
						d.shift = {q.shift[6:0], 1'b0};
						d.sdaOe = ~q.shift[6];
						d.bitCnt = q.bitCnt + `TPSC_BIT_FIRST;
					end
				end
				PH_READ_ACK: begin
					if (sclRise) begin
						d.ackSeen = ~sdaS;
						if (sdaS) begin
							d.phase = PH_IDLE;
							d.por = 1'b0;
						end
					end else if (sclFall && q.ackSeen) begin
						d.shift = statusByte;
						d.sdaOe = ~statusByte[`TPSC_MSB];
						d.bitCnt = `TPSC_BIT_FIRST;
						d.phase = PH_READ;
					end
				end
				default: begin
					d.phase = PH_IDLE;
					d.sdaOe = 1'b0;
				end
			endcase
		end

		// ----------------------------------------
		// Decode of the stored bytes
		// ----------------------------------------
		d.cfg.pumpCurrentSelect = d.cb[`TPSC_CB_CP];
		d.cfg.tuningOutputOff = d.cb[`TPSC_CB_OS];
		d.cfg.halfRefOnPort6 = 1'b0;
		d.cfg.halfDivOnPort6 = 1'b0;
		case (d.cb[`TPSC_CB_T_HI:`TPSC_CB_T_LO])
			`TPSC_TEST_PUMP_OFF: d.cfg.pumpMode = PUMP_OFF;
			`TPSC_TEST_SINK: d.cfg.pumpMode = PUMP_SINK;
			`TPSC_TEST_SOURCE: d.cfg.pumpMode = PUMP_SOURCE;
			`TPSC_TEST_HALF_REF: begin
				d.cfg.pumpMode = PUMP_NORMAL;
				d.cfg.halfRefOnPort6 = 1'b1;
			end
			`TPSC_TEST_HALF_DIV: begin
				d.cfg.pumpMode = PUMP_NORMAL;
				d.cfg.halfDivOnPort6 = 1'b1;
			end
			default: d.cfg.pumpMode = PUMP_NORMAL;
		endcase
		// Converter code meaningless while port6 carries a test clock
		d.cfg.converterBlocked = d.cfg.halfRefOnPort6 | d.cfg.halfDivOnPort6;
		d.cfg.refRatioForbidden = 1'b0;
		case (d.cb[`TPSC_CB_RS_HI:`TPSC_CB_RS_LO])
			`TPSC_RS_80: d.cfg.refRatio = `TPSC_RATIO_80;
			`TPSC_RS_128: d.cfg.refRatio = `TPSC_RATIO_128;
			`TPSC_RS_BAD: begin
				// Forbidden setting, keep a safe ratio and flag it
				d.cfg.refRatio = `TPSC_RATIO_80;
				d.cfg.refRatioForbidden = 1'b1;
			end
			default: d.cfg.refRatio = `TPSC_RATIO_64;
		endcase
		d.cfg.gainTimeConstant = d.ab[`TPSC_AB_ATC];
		d.cfg.agcDetectorOn = 1'b1;
		d.cfg.agcOutHiZ = 1'b0;
		d.cfg.agcOutForced = 1'b0;
		case (d.ab[`TPSC_AB_AL_HI:`TPSC_AB_AL_LO])
			`TPSC_AL_112: d.cfg.takeoverDbuv = `TPSC_DB_112;
			`TPSC_AL_109: d.cfg.takeoverDbuv = `TPSC_DB_109;
			`TPSC_AL_106: d.cfg.takeoverDbuv = `TPSC_DB_106;
			`TPSC_AL_103: d.cfg.takeoverDbuv = `TPSC_DB_103;
			`TPSC_AL_EXT: begin
				d.cfg.takeoverDbuv = `TPSC_DB_NONE;
				d.cfg.agcDetectorOn = 1'b0;
				d.cfg.agcOutHiZ = 1'b1;
			end
			`TPSC_AL_FIXED: begin
				d.cfg.takeoverDbuv = `TPSC_DB_NONE;
				d.cfg.agcDetectorOn = 1'b0;
				d.cfg.agcOutForced = 1'b1;
			end
			default: d.cfg.takeoverDbuv = `TPSC_DB_115;
		endcase
		d.cfg.portBits = d.bb;
		d.cfg.highBandSelect = ~d.bb[`TPSC_BB_P0] & ~d.bb[`TPSC_BB_P1];
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.sclPrev <= 1'b1;
			q.sdaPrev <= 1'b1;
			q.phase <= PH_IDLE;
			q.ptr <= PT_FIRST;
			q.cb <= `TPSC_CB_RESET;
			q.bb <= `TPSC_BB_RESET;
			q.ab <= `TPSC_AB_RESET;
			q.por <= 1'b1;
			q.cfg.dividerCount <= `TPSC_DIV_RESET;
			q.cfg.pumpCurrentSelect <= 1'b1;
			q.cfg.pumpMode <= PUMP_NORMAL;
			q.cfg.refRatio <= `TPSC_RATIO_80;
			q.cfg.takeoverDbuv <= `TPSC_DB_112;
			q.cfg.agcDetectorOn <= 1'b1;
			q.cfg.tuningOutputOff <= 1'b1;
			q.cfg.highBandSelect <= 1'b1;
		end else if (ce) begin
			q <= d;
		end
	end

	assign sdaOut = q.sdaOut;
	assign sdaOe = q.sdaOe;
	assign tunerCfg = q.cfg;
	assign porFlag = q.por;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic tick;
	assign tick = ce & ~startSeen & ~stopSeen;

	AST_ADDR_MISS: assert property (@(posedge clk) disable iff (rst)
		(tick && q.phase == PH_ADDR && byteDone && !addrMatch)
		|=> (q.phase == PH_IDLE && !q.sdaOe))
		else $error("foreign address not ignored");

	AST_ADDR_ACK: assert property (@(posedge clk) disable iff (rst)
		(tick && q.phase == PH_ADDR && byteDone && addrMatch)
		|=> (q.sdaOe && q.phase == PH_ADDR_ACK))
		else $error("own address not acknowledged");

	AST_SDA_HOLD: assert property (@(posedge clk) disable iff (rst)
		q.sclPrev |-> $stable(q.sdaOe))
		else $error("data line moved while clock high");

	AST_STATUS_LOAD: assert property (@(posedge clk) disable iff (rst)
		(tick && q.phase == PH_ADDR_ACK && sclFall && q.isRead)
		|=> (q.shift[5:4] == `TPSC_STATUS_ONES && q.shift[7] == $past(q.por)
		&& q.sdaOe == !q.shift[7] && q.bitCnt == `TPSC_BIT_FIRST))
		else $error("status byte not loaded");

	AST_NACK_END: assert property (@(posedge clk) disable iff (rst)
		(tick && q.phase == PH_READ_ACK && sclRise && sdaS)
		|=> (!q.por && q.phase == PH_IDLE && !q.sdaOe) ##1 !q.por)
		else $error("read end did not clear power-on flag");

	AST_ACK_MORE: assert property (@(posedge clk) disable iff (rst)
		(tick && q.phase == PH_READ_ACK && sclFall && q.ackSeen)
		|=> (q.phase == PH_READ && q.bitCnt == `TPSC_BIT_FIRST))
		else $error("master ack did not start next byte");

	AST_AUX_TAKE: assert property (@(posedge clk) disable iff (rst)
		(tick && q.phase == PH_WRITE && byteDone && ptrSel == PT_PORT
		&& q.cb[`TPSC_CB_T_HI:`TPSC_CB_T_LO] == `TPSC_TEST_AUX)
		|=> (q.ab == $past(q.shift) && $stable(q.bb)))
		else $error("gain byte not taken after test code");

	AST_DIV_LOAD: assert property (@(posedge clk) disable iff (rst)
		(tick && q.phase == PH_WRITE && byteDone && ptrSel == PT_DIV2)
		|=> (q.cfg.dividerCount == {$past(q.db1), $past(q.shift)}))
		else $error("divider not loaded on eighth clock");

	AST_RATIO: assert property (@(posedge clk) disable iff (rst)
		(q.cb[`TPSC_CB_RS_HI:`TPSC_CB_RS_LO] == `TPSC_RS_128)
		|-> (q.cfg.refRatio == `TPSC_RATIO_128))
		else $error("reference ratio decode wrong");

	AST_AGC_EXT: assert property (@(posedge clk) disable iff (rst)
		(q.ab[`TPSC_AB_AL_HI:`TPSC_AB_AL_LO] == `TPSC_AL_EXT)
		|-> (q.cfg.agcOutHiZ && !q.cfg.agcDetectorOn && !q.cfg.agcOutForced))
		else $error("external gain mode not decoded");

	AST_PUMP_SINK: assert property (@(posedge clk) disable iff (rst)
		(q.cb[`TPSC_CB_T_HI:`TPSC_CB_T_LO] == `TPSC_TEST_SINK)
		|-> (q.cfg.pumpMode == PUMP_SINK))
		else $error("pump sink mode not decoded");

	COV_READ_END: cover property (@(posedge clk) disable iff (rst)
		q.phase == PH_READ_ACK ##1 q.phase == PH_IDLE);
	COV_AUX_WRITE: cover property (@(posedge clk) disable iff (rst)
		tick && byteDone && q.phase == PH_WRITE && ptrSel == PT_PORT
		&& q.cb[`TPSC_CB_T_HI:`TPSC_CB_T_LO] == `TPSC_TEST_AUX);
	COV_FULL_WRITE: cover property (@(posedge clk) disable iff (rst)
		tick && byteDone && q.phase == PH_WRITE && ptrSel == PT_PORT && !q.fromCtl);
	COV_TWO_READS: cover property (@(posedge clk) disable iff (rst)
		tick && q.phase == PH_READ_ACK && sclFall && q.ackSeen);
endmodule : tpsc_serial_ctrl
`default_nettype wire

/* File: test/tpsc_master_model.sv */
// Purpose: Two-wire bus master standing in for the microcontroller
// Assumes: sda has a pull-up; the wire level comes back on sdaWire
// Notes:   Eight clk per step, scl high for eight and low for sixteen per bit, twice the minimum the slave needs
`default_nettype none
module tpsc_master_model (
	input wire logic clk,
	input wire logic sdaWire,
	output logic scl,
	output logic sdaLow,
	output int glitches
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
		glitches = 0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	// ----------------------------------------
	// Framing
	// ----------------------------------------
	task automatic start();
		sdaLow <= 1'b1;
		tick(8);
		scl <= 1'b0;
		tick(8);
	endtask : start
	task automatic stop();
		sdaLow <= 1'b1;
		tick(8);
		scl <= 1'b1;
		tick(8);
		sdaLow <= 1'b0;
		tick(8);
	endtask : stop
	// Data set only while scl low; wire sampled early and late in the high phase
	task automatic bitCycle(input logic b, output logic r);
		logic r0;
		sdaLow <= !b;
		tick(8);
		scl <= 1'b1;
		tick(2);
		r0 = sdaWire;
		tick(6);
		r = sdaWire;
		if (r !== r0) begin
			glitches++;
		end
		scl <= 1'b0;
		tick(8);
	endtask : bitCycle
	task automatic wrByte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitCycle(d[i], r);
		end
		bitCycle(1'b1, r);
		ack = !r;
	endtask : wrByte
	// Released line during data bits, so only the slave pulls it low
	task automatic rdByte(input logic ackIt, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitCycle(1'b1, d[i]);
		end
		bitCycle(!ackIt, r);
	endtask : rdByte
endmodule : tpsc_master_model
`default_nettype wire

/* File: test/tpsc_serial_ctrl_tb_top.sv */
// Purpose: Self-checking bench of the serial control block
// Assumes: Master model drives scl and pulls sda; pull-up resolves the wire
// Notes:   One task per scenario; ce stays high after reset
`default_nettype none
module tpsc_serial_ctrl_tb_top;
	import tpsc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, ce, scl, sdaLow, sdaOut, sdaOe, loopLocked, agcTakeoverReached, porFlag;
	logic [2:0] addrStrapPinLevel;
	logic [3:0] convCompare;
	logic [1:0] strapExp;
	tpsc_cfg_t tunerCfg;
	wire logic sdaWire;
	int n_fail, total_checks, cycles, glitches;
	assign sdaWire = !(sdaLow | sdaOe);
	tpsc_serial_ctrl u_dut (.clk(clk), .rst(rst), .ce(ce), .scl(scl), .sdaIn(sdaWire),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .addrStrapPinLevel(addrStrapPinLevel),
		.convCompare(convCompare), .loopLocked(loopLocked),
		.agcTakeoverReached(agcTakeoverReached), .tunerCfg(tunerCfg), .porFlag(porFlag));
	tpsc_master_model u_master (.clk(clk), .sdaWire(sdaWire), .scl(scl), .sdaLow(sdaLow),
		.glitches(glitches));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	function automatic logic [7:0] adr(input logic rw);
		return {5'h18, strapExp, rw};
	endfunction : adr
	task automatic send(input logic [7:0] q[$]);
		logic ack;
		u_master.start();
		foreach (q[i]) begin
			u_master.wrByte(q[i], ack);
			check(ack, 1'b1);
		end
		u_master.stop();
	endtask : send
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		check(porFlag, 1'b1);
		check({sdaOe, sdaOut}, 2'h0);
		check(tunerCfg.pumpCurrentSelect, 1'b1);
		check(tunerCfg.pumpMode, PUMP_NORMAL);
		check(tunerCfg.takeoverDbuv, 7'h70);
		check(tunerCfg.gainTimeConstant, 1'b0);
		check(tunerCfg.tuningOutputOff, 1'b1);
		check({tunerCfg.portBits, tunerCfg.highBandSelect}, 9'h001);
	endtask : t_reset
	task automatic t_divider();
		send('{adr(1'b0), 8'h12, 8'h34, 8'h88, 8'h03});
		check(tunerCfg.dividerCount, 15'h1234);
		check(tunerCfg.pumpCurrentSelect, 1'b0);
		check(tunerCfg.tuningOutputOff, 1'b0);
		check({tunerCfg.portBits, tunerCfg.highBandSelect}, 9'h006);
		// Lone upper byte must not disturb the divider
		send('{adr(1'b0), 8'h7f});
		check(tunerCfg.dividerCount, 15'h1234);
	endtask : t_divider
	task automatic t_test();
		tpsc_pump_t pm;
		for (int c = 0; c < 8; c++) begin
			if (c != 3) begin
				send('{adr(1'b0), {2'b11, 3'(c), 3'b001}});
				pm = (c == 2) ? PUMP_OFF : (c == 6) ? PUMP_SINK : (c == 7) ? PUMP_SOURCE : PUMP_NORMAL;
				check(tunerCfg.pumpMode, pm);
				check(tunerCfg.halfRefOnPort6, c == 4);
				check(tunerCfg.halfDivOnPort6, c == 5);
				check(tunerCfg.converterBlocked, c == 4 || c == 5);
			end
		end
	endtask : t_test
	task automatic t_gain();
		logic [6:0] db[8] = '{7'h73, 7'h73, 7'h70, 7'h6d, 7'h6a, 7'h67, 7'h00, 7'h00};
		for (int al = 0; al < 8; al++) begin
			send('{adr(1'b0), 8'hd9, {1'b1, 3'(al), 4'h0}});
			check(tunerCfg.takeoverDbuv, db[al]);
			check(tunerCfg.agcDetectorOn, al < 6);
			check({tunerCfg.agcOutHiZ, tunerCfg.agcOutForced}, {al == 6, al == 7});
			check({tunerCfg.gainTimeConstant, tunerCfg.portBits}, 9'h103);
		end
	endtask : t_gain
	task automatic t_ratio();
		logic [1:0] rs[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
		logic [7:0] ratio[4] = '{8'h50, 8'h80, 8'h40, 8'h50};
		for (int i = 0; i < 4; i++) begin
			send('{adr(1'b0), {5'h19, rs[i], 1'b1}});
			check(tunerCfg.refRatio, ratio[i]);
			check(tunerCfg.refRatioForbidden, i == 3);
		end
	endtask : t_ratio
	task automatic t_address();
		logic ack;
		for (int s = 0; s < 4; s++) begin
			addrStrapPinLevel <= 3'((1 << s) - 1);
			strapExp = 2'(s);
			u_master.tick(8);
			u_master.start();
			u_master.wrByte(adr(1'b0) ^ 8'h02, ack);
			check({ack, sdaOe}, 2'h0);
			u_master.stop();
			send('{adr(1'b0), 8'hc9});
		end
	endtask : t_address
	task automatic t_read();
		logic [7:0] d;
		logic ack;
		logic [3:0] th[5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf};
		loopLocked <= 1'b1;
		agcTakeoverReached <= 1'b1;
		convCompare <= 4'h7;
		u_master.start();
		u_master.wrByte(adr(1'b1), ack);
		check(ack, 1'b1);
		u_master.rdByte(1'b1, d);
		check(d, 8'hfb);
		u_master.rdByte(1'b0, d);
		check(d, 8'hfb);
		check(porFlag, 1'b0);
		u_master.stop();
		check({porFlag, sdaOe}, 2'h0);
		for (int i = 0; i < 5; i++) begin
			loopLocked <= i[0];
			agcTakeoverReached <= !i[0];
			convCompare <= th[i];
			u_master.start();
			u_master.wrByte(adr(1'b1), ack);
			u_master.rdByte(1'b0, d);
			u_master.stop();
			check(d, {1'b0, i[0], 2'b11, !i[0], 3'(i)});
		end
		check(glitches, 0);
	endtask : t_read
	// ----------------------------------------
	// Sequence and watchdog
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		ce = 1'b0;
		loopLocked = 1'b0;
		agcTakeoverReached = 1'b0;
		addrStrapPinLevel = 3'h1;
		convCompare = 4'h0;
		strapExp = 2'h1;
		n_fail = 0;
		total_checks = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		ce <= 1'b1;
		u_master.tick(8);
		t_reset();
		t_divider();
		t_test();
		t_gain();
		t_ratio();
		t_address();
		t_read();
		complete_run();
	end
	// Whole run needs about 18300 clk
	initial begin
		cycles = 0;
		forever begin
			@(posedge clk);
			cycles++;
			if (cycles == 80000) begin
				n_fail++;
				complete_run();
			end
		end
	end
endmodule : tpsc_serial_ctrl_tb_top
`default_nettype wire
